// ### design/mcf_pkg.sv
package mcf_pkg;
	// register indices (word addresses)
	localparam logic [3:0] MCF_ADDR_FLAGS = 4'h0;
	localparam logic [3:0] MCF_ADDR_ERRCODE = 4'h1;
	localparam logic [3:0] MCF_ADDR_IRQ_STAT = 4'h2;
	localparam logic [3:0] MCF_ADDR_IRQ_MASK = 4'h3;
	localparam logic [3:0] MCF_ADDR_CTRL = 4'h4;
	localparam int MCF_AW = 4;
	localparam int MCF_DW = 32;
	// flag bit positions in the flags register
	localparam int MCF_B_PEER2_RST = 0;
	localparam int MCF_B_PEER3_RST = 1;
	localparam int MCF_B_PEER4_RST = 2;
	localparam int MCF_B_ERR1 = 3;
	localparam int MCF_B_ERR2 = 4;
	localparam int MCF_B_ERR3 = 5;
	localparam int MCF_B_ERR4 = 6;
	localparam int MCF_B_ONE = 7;
	localparam int MCF_B_ZERO = 8;
	localparam int MCF_B_READY = 9;
	localparam int MCF_B_TEST = 10;
	localparam int MCF_B_FSTOP = 11;
	localparam int MCF_B_SCOPE = 12;
	localparam int MCF_B_CAM_WRITE_COMMAND = 13;
	localparam int MCF_B_FSTOP_LATCH = 14;
	localparam int MCF_B_TEST_ERR = 15;
	localparam int MCF_B_MCPU_DOWN = 16;
	localparam int MCF_NFLAGS = 17;
	// interrupt event bits
	localparam int MCF_EV_DOWN = 0;
	localparam int MCF_EV_FSTOP = 1;
	localparam int MCF_EV_READY = 2;
	localparam int MCF_EV_PARAM_ERR = 3;
	localparam int MCF_EV_TEST_ERR = 4;
	localparam int MCF_NEV = 5;
	// control register bits
	localparam int MCF_C_HOST_READY = 0;
	localparam logic [15:0] MCF_DOWN_CODE = 16'h1B58;
	localparam logic [15:0] MCF_NO_CODE = 16'h0000;
	localparam logic [MCF_NEV-1:0] MCF_MASK_RST = '0;
endpackage : mcf_pkg

// ### design/mcf_flag_bank.sv
// What this block does
// RL1: peer resetting flags follow peer reset inputs
// RL2: peer reset forces multi-CPU-down, code 7000
// RL3: stop error flags follow CPU stop errors
// RL4: ready rise checks parameters, sets ready
// RL5: host ready low clears ready flag
// RL6: test request sets test or error flag
// RL7: forced stop flag mirrors input on each op cycle tick
// RL8: scope flag high while scope stopped
// RL9: cam flag high during cam commands
// RL10: forced stop latch set on detection
// RL11: latch cleared only by reset
// RL12: constant one and zero flags
`timescale 1ns/1ns
`default_nettype none
// three-stage synchroniser for one pin
module mcf_sync3 (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic pin_async,
	output logic level_q
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	// first stage, may go metastable
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s1_q <= 1'b0;
		end else begin
			s1_q <= pin_async;
		end
	end

	// second stage, only reader of the first
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s2_q <= 1'b0;
		end else begin
			s2_q <= s1_q;
		end
	end

	// third stage
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s3_q <= 1'b0;
		end else begin
			s3_q <= s2_q;
		end
	end

	// change accepted when stages 2 and 3 agree
	// filters a single-cycle disagreement
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			level_q <= 1'b0;
		end else if (s2_q == s3_q) begin
			level_q <= s3_q;
		end
	end
endmodule : mcf_sync3

module mcf_flag_bank (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [2:0] peer_reset_pin,
	input wire logic [3:0] cpu_stop_error,
	input wire logic op_cycle_tick,
	input wire logic param_check_done,
	input wire logic param_check_error,
	input wire logic test_request,
	input wire logic test_established,
	input wire logic forced_stop_pin,
	input wire logic scope_executing,
	input wire logic cam_write_command,
	input wire logic cam_open_area_write_command,
	input wire logic cam_autogen_command,
	input wire logic [mcf_pkg::MCF_AW-1:0] reg_addr,
	input wire logic [mcf_pkg::MCF_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [mcf_pkg::MCF_DW-1:0] reg_rdata,
	output logic param_check_start,
	output logic mcpu_down,
	output logic irq
);
	import mcf_pkg::*;

	typedef enum logic {
		MCF_CK_IDLE = 1'b0,
		MCF_CK_BUSY = 1'b1
	} mcf_check_t;

	wire logic [2:0] prst_q;
	wire logic fs_in_q;
	logic host_ready_q;
	logic host_ready_prev_q;
	mcf_check_t check_state_q;
	logic ready_q;
	logic test_q;
	logic test_err_q;
	logic fstop_q;
	logic latch_q;
	logic down_q;
	logic [15:0] errcode_q;
	logic [MCF_NEV-1:0] stat_q;
	logic [MCF_NEV-1:0] mask_q;
	logic [MCF_NEV-1:0] ev;
	logic [MCF_NFLAGS-1:0] flags;
	logic host_ready_rise;
	logic fs_rise;
	logic checking;
	logic check_ok;
	logic check_bad;
	logic ctrl_wr;
	logic stat_wr;
	logic mask_wr;

	// RL1: one synchroniser per peer reset pin
	for (genvar g = 0; g < $bits(peer_reset_pin); g++) begin : g_peer_sync
		mcf_sync3 i_sync (
			.sys_clk(sys_clk),
			.rst(rst),
			.pin_async(peer_reset_pin[g]),
			.level_q(prst_q[g])
		);
	end

	// RL10: forced stop pin synchroniser
	mcf_sync3 i_fs_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.pin_async(forced_stop_pin),
		.level_q(fs_in_q)
	);

	// register port write decodes
	assign ctrl_wr = reg_wr && (reg_addr == MCF_ADDR_CTRL);
	assign stat_wr = reg_wr && (reg_addr == MCF_ADDR_IRQ_STAT);
	assign mask_wr = reg_wr && (reg_addr == MCF_ADDR_IRQ_MASK);

	// RL2: multi-CPU-down stop, sticky until reset
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			down_q <= 1'b0;
		end else if (|prst_q) begin
			down_q <= 1'b1;
		end
	end

	// RL2: error code 7000 with the stop
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			errcode_q <= MCF_NO_CODE;
		end else if (|prst_q) begin
			errcode_q <= MCF_DOWN_CODE;
		end
	end

	// host ready from control register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			host_ready_q <= 1'b0;
		end else if (ctrl_wr) begin
			host_ready_q <= reg_wdata[MCF_C_HOST_READY];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			host_ready_prev_q <= 1'b0;
		end else begin
			host_ready_prev_q <= host_ready_q;
		end
	end

	assign host_ready_rise = host_ready_q && !host_ready_prev_q;
	assign param_check_start = host_ready_rise;

	// RL4: check busy from ready rise to done
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			check_state_q <= MCF_CK_IDLE;
		end else if (!host_ready_q) begin
			check_state_q <= MCF_CK_IDLE;
		end else begin
			unique case (check_state_q)
				MCF_CK_IDLE: begin
					if (host_ready_rise) begin
						check_state_q <= MCF_CK_BUSY;
					end
				end
				MCF_CK_BUSY: begin
					if (param_check_done) begin
						check_state_q <= MCF_CK_IDLE;
					end
				end
			endcase
		end
	end

	assign checking = (check_state_q == MCF_CK_BUSY);
	// RL4: outcome counts only while host ready holds
	assign check_ok = checking && param_check_done && !param_check_error &&
		host_ready_q;
	assign check_bad = checking && param_check_done && param_check_error &&
		host_ready_q;

	// RL4 RL5: ready flag set and clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ready_q <= 1'b0;
		end else if (!host_ready_q || host_ready_rise || check_bad) begin
			// RL5: host ready low clears
			ready_q <= 1'b0;
		end else if (check_ok) begin
			ready_q <= 1'b1;
		end
	end

	// RL6: test mode flag
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			test_q <= 1'b0;
		end else if (test_request) begin
			test_q <= test_established;
		end
	end

	// RL6: test request error flag
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			test_err_q <= 1'b0;
		end else if (test_request) begin
			test_err_q <= !test_established;
		end
	end

	// RL7: mirror forced stop on each op cycle tick
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			fstop_q <= 1'b0;
		end else if (op_cycle_tick) begin
			fstop_q <= fs_in_q;
		end
	end

	// RL10: latch forced stop; RL11: reset clears
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			latch_q <= 1'b0;
		end else if (fs_in_q) begin
			latch_q <= 1'b1;
		end
	end

	assign fs_rise = fs_in_q && !latch_q;

	// interrupt events
	always_comb begin
		ev = '0;
		ev[MCF_EV_DOWN] = |prst_q && !down_q;
		ev[MCF_EV_FSTOP] = fs_rise;
		ev[MCF_EV_READY] = check_ok;
		ev[MCF_EV_PARAM_ERR] = check_bad;
		ev[MCF_EV_TEST_ERR] = test_request && !test_established;
	end

	// sticky status, write one clears, set wins
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			stat_q <= '0;
		end else if (stat_wr) begin
			stat_q <= (stat_q & ~reg_wdata[MCF_NEV-1:0]) | ev;
		end else begin
			stat_q <= stat_q | ev;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mask_q <= MCF_MASK_RST;
		end else if (mask_wr) begin
			mask_q <= reg_wdata[MCF_NEV-1:0];
		end
	end

	assign irq = |(stat_q & mask_q);
	assign mcpu_down = down_q;

	// flag word
	always_comb begin
		flags = '0;
		flags[MCF_B_PEER2_RST] = prst_q[0];
		flags[MCF_B_PEER3_RST] = prst_q[1];
		flags[MCF_B_PEER4_RST] = prst_q[2];
		// RL3: stop error flags
		flags[MCF_B_ERR1] = cpu_stop_error[0];
		flags[MCF_B_ERR2] = cpu_stop_error[1];
		flags[MCF_B_ERR3] = cpu_stop_error[2];
		flags[MCF_B_ERR4] = cpu_stop_error[3];
		// RL12: constant flags
		flags[MCF_B_ONE] = 1'b1;
		flags[MCF_B_ZERO] = 1'b0;
		flags[MCF_B_READY] = ready_q;
		flags[MCF_B_TEST] = test_q;
		flags[MCF_B_FSTOP] = fstop_q;
		// RL8: high while scope stopped
		flags[MCF_B_SCOPE] = !scope_executing;
		// RL9: any cam command busy
		flags[MCF_B_CAM_WRITE_COMMAND] = cam_write_command ||
			cam_open_area_write_command || cam_autogen_command;
		flags[MCF_B_FSTOP_LATCH] = latch_q;
		flags[MCF_B_TEST_ERR] = test_err_q;
		flags[MCF_B_MCPU_DOWN] = down_q;
	end

	// read data one cycle after strobe
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				MCF_ADDR_FLAGS: reg_rdata <= MCF_DW'(flags);
				MCF_ADDR_ERRCODE: reg_rdata <= MCF_DW'(errcode_q);
				MCF_ADDR_IRQ_STAT: reg_rdata <= MCF_DW'(stat_q);
				MCF_ADDR_IRQ_MASK: reg_rdata <= MCF_DW'(mask_q);
				MCF_ADDR_CTRL: reg_rdata <= MCF_DW'(host_ready_q);
				default: reg_rdata <= '0;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end
endmodule : mcf_flag_bank
`default_nettype wire

// ### dv/mcf_flag_bank_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module mcf_flag_bank_monitor
	import mcf_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [2:0] peer_reset_pin,
	input wire logic [3:0] cpu_stop_error,
	input wire logic scope_executing,
	input wire logic cam_write_command,
	input wire logic cam_open_area_write_command,
	input wire logic cam_autogen_command,
	input wire logic [mcf_pkg::MCF_AW-1:0] reg_addr,
	input wire logic [mcf_pkg::MCF_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [mcf_pkg::MCF_DW-1:0] reg_rdata,
	input wire logic param_check_start,
	input wire logic mcpu_down
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic rd_q;
	logic seen_q;
	// flags read tracking
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rd_q <= 1'h0;
			seen_q <= 1'h0;
		end else begin
			rd_q <= reg_rd && reg_addr == MCF_ADDR_FLAGS;
			if (rd_q && reg_rdata[MCF_B_FSTOP_LATCH]) seen_q <= 1'h1;
		end
	end
	sequence flags_rd;
		rd_q;
	endsequence
	sequence ctrl_set;
		$past(reg_wr) && $past(reg_addr) == MCF_ADDR_CTRL && $past(reg_wdata[0]);
	endsequence
	const_flags_a: assert property (flags_rd |-> reg_rdata[8:7] == 2'h1)
		else $error("constant flags wrong");
	stop_err_a: assert property (flags_rd |-> reg_rdata[6:3] == $past(cpu_stop_error))
		else $error("stop error flags wrong");
	scope_flag_a: assert property (flags_rd |-> reg_rdata[12] != $past(scope_executing))
		else $error("scope flag wrong");
	cam_flag_a: assert property (flags_rd |-> reg_rdata[13] == $past(cam_write_command
		| cam_open_area_write_command | cam_autogen_command)) else $error("cam flag wrong");
	down_entry_a: assert property ((|peer_reset_pin) [*6] |-> ##[0:2] mcpu_down)
		else $error("down state not entered");
	down_sticky_a: assert property (mcpu_down |=> mcpu_down)
		else $error("down state dropped");
	check_start_a: assert property (param_check_start |-> ctrl_set)
		else $error("check start without ready rise");
	latch_hold_a: assert property (flags_rd and seen_q |-> reg_rdata[14])
		else $error("forced stop latch lost");
endmodule : mcf_flag_bank_monitor
bind mcf_flag_bank mcf_flag_bank_monitor i_mon (.*);
`default_nettype wire

// ### dv/mcf_peer_model.sv
`timescale 1ns/1ns
`default_nettype none
module mcf_peer_model (
	input wire logic sys_clk,
	input wire logic [2:0] hold_rst,
	input wire logic [3:0] stop_err,
	output logic [2:0] peer_reset_pin,
	output logic [3:0] cpu_stop_error
);
	initial peer_reset_pin = 3'h0;
	initial cpu_stop_error = 4'h0;
	always @(posedge sys_clk) peer_reset_pin <= hold_rst;
	always @(posedge sys_clk) cpu_stop_error <= stop_err;
endmodule : mcf_peer_model
`default_nettype wire

// ### dv/mcf_flag_bank_tb.sv
`timescale 1ns/1ns
`default_nettype none
module mcf_flag_bank_tb;
	import mcf_pkg::*;
	logic sys_clk = '0, rst = '1, op_cycle_tick = '0, reg_wr = '0, reg_rd = '0;
	logic param_check_done = '0, param_check_error = '0, test_request = '0;
	logic test_established = '0, forced_stop_pin = '0, scope_executing = '0;
	logic cam_write_command = '0, cam_open_area_write_command = '0;
	logic cam_autogen_command = '0, param_check_start, mcpu_down, irq;
	logic [2:0] hold_rst = '0, peer_reset_pin;
	logic [3:0] stop_err = '0, cpu_stop_error, reg_addr = '0;
	logic [31:0] reg_wdata = '0, reg_rdata, d;
	logic ready_e = '0, test_e = '0, terr_e = '0, fs_e = '0, latch_e = '0, down_e = '0;
	logic [7:0] rnd = 8'h1F;
	int n_errors = 0, comparisons = 0, i;
	mcf_flag_bank i_dut (.*);
	mcf_peer_model i_peer (.*);
	always #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk) op_cycle_tick <= ~op_cycle_tick;
	always @(posedge sys_clk) param_check_done <= param_check_start;
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	function automatic logic [31:0] exp_flags();
		return {15'h0, down_e, terr_e, latch_e, cam_write_command |
			cam_open_area_write_command | cam_autogen_command,
			~scope_executing, fs_e, test_e, ready_e, 2'h1, stop_err, hold_rst};
	endfunction : exp_flags
	task automatic give_verdict();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : give_verdict
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask : cmp
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'h1;
		@(posedge sys_clk);
		reg_wr <= 1'h0;
		@(posedge sys_clk);
	endtask : wr
	task automatic chk(input logic [3:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge sys_clk);
		reg_rd <= 1'h0;
		@(negedge sys_clk);
		cmp("reg", e, reg_rdata);
		@(posedge sys_clk);
	endtask : chk
	task automatic st();
		repeat (8) @(posedge sys_clk);
	endtask : st
	task automatic treq(input logic est);
		test_established <= est;
		test_request <= 1'h1;
		@(posedge sys_clk);
		test_request <= 1'h0;
		st();
	endtask : treq
	initial begin
		#500000;
		n_errors++;
		give_verdict();
	end
	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'h0;
		@(posedge sys_clk);
		chk(MCF_ADDR_FLAGS, exp_flags());
		chk(4'hF, 32'h0);
		chk(MCF_ADDR_IRQ_MASK, 32'h0);
		for (i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			{cam_autogen_command, cam_open_area_write_command, cam_write_command,
				scope_executing, stop_err} <= rnd;
			st();
			chk(MCF_ADDR_FLAGS, exp_flags());
		end
		param_check_error <= 1'h1;
		wr(MCF_ADDR_CTRL, 32'h1);
		st();
		chk(MCF_ADDR_FLAGS, exp_flags());
		wr(MCF_ADDR_CTRL, 32'h0);
		param_check_error <= 1'h0;
		wr(MCF_ADDR_CTRL, 32'h1);
		st();
		ready_e = 1'h1;
		chk(MCF_ADDR_FLAGS, exp_flags());
		chk(MCF_ADDR_IRQ_STAT, 32'hC);
		wr(MCF_ADDR_CTRL, 32'h0);
		st();
		ready_e = 1'h0;
		chk(MCF_ADDR_FLAGS, exp_flags());
		treq(1'h0);
		terr_e = 1'h1;
		chk(MCF_ADDR_FLAGS, exp_flags());
		treq(1'h1);
		{test_e, terr_e} = 2'h2;
		chk(MCF_ADDR_FLAGS, exp_flags());
		wr(MCF_ADDR_IRQ_STAT, 32'h1F);
		forced_stop_pin <= 1'h1;
		st();
		{fs_e, latch_e} = 2'h3;
		chk(MCF_ADDR_FLAGS, exp_flags());
		cmp("irq", 32'h0, irq);
		wr(MCF_ADDR_IRQ_MASK, 32'h2);
		@(negedge sys_clk) cmp("irq", 32'h1, irq);
		forced_stop_pin <= 1'h0;
		st();
		fs_e = 1'h0;
		chk(MCF_ADDR_FLAGS, exp_flags());
		wr(MCF_ADDR_IRQ_STAT, 32'h1F);
		@(negedge sys_clk) cmp("irq", 32'h0, irq);
		for (i = 0; i < 3; i++) begin
			hold_rst <= 3'h1 << i;
			st();
			down_e = 1'h1;
			chk(MCF_ADDR_FLAGS, exp_flags());
			cmp("down", 32'h1, mcpu_down);
			hold_rst <= 3'h0;
			st();
			chk(MCF_ADDR_FLAGS, exp_flags());
		end
		chk(MCF_ADDR_ERRCODE, 32'h1B58);
		give_verdict();
	end
endmodule : mcf_flag_bank_tb
`default_nettype wire
